// >>> lcd_host_pkg.sv
package lcd_host_pkg;
   // ==========================================================
   // Bus styles chosen by the two interface-select straps.
   // ==========================================================
   typedef enum logic [1:0] {
      BUS_RESET  = 2'h0,
      BUS_SERIAL = 2'h1,
      BUS_STROBE = 2'h2,
      BUS_ENABLE = 2'h3
   } bus_style_e;

   // Strap levels: {bus_type_pin_a, bus_type_pin_b}.
   localparam logic [1:0] STRAP_STROBE = 2'h1;
   localparam logic [1:0] STRAP_ENABLE = 2'h3;
   localparam logic [1:0] STRAP_SERIAL = 2'h2;
   localparam logic [1:0] STRAP_RESET = 2'h0;

   // ==========================================================
   // Widths and positions.
   // ==========================================================
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 32;
   // A FIFO word carries the data/command flag above the byte.
   localparam int WORD_W = DATA_W + 1;
   localparam int FLAG_BIT = DATA_W;
   // Serial data line and serial clock line within the bus.
   localparam int SER_DATA_BIT = 7;
   localparam int SER_CLK_BIT = 6;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] BIT_FIRST = 3'h0;

   // ==========================================================
   // Timing: each strobe phase lasts at least this long.
   // ==========================================================
   localparam int PHASE_NS = 100;
   localparam int CLK_NS = 10;
   localparam logic [3:0] PHASE_CYC = 4'((PHASE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] CNT_ZERO = 4'h0;

   // ==========================================================
   // Sequencer states, Gray coded along the usual path.
   // ==========================================================
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_SETUP = 3'b001,
      ST_ACT   = 3'b011,
      ST_HOLD  = 3'b010,
      ST_SLOW  = 3'b110,
      ST_SHIGH = 3'b111
   } seq_state_e;
endpackage : lcd_host_pkg

// >>> lcd_host_fifo.sv
`timescale 1ns/1ps
module lcd_host_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rstn,
   // Filling side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side.
   input wire logic out_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   // ==========================================================
   // Storage and pointers.
   // ==========================================================
   logic [WIDTH-1:0] mem [DEPTH];  // Word storage.
   logic [AW-1:0] wr_q;  // Next slot written.
   logic [AW-1:0] rd_q;  // Next slot read.
   logic [AW:0] cnt_q;  // Words held.
   logic [AW:0] cnt_d;  // Words held after this edge.
   logic ready_q;  // Room for one more word; a flop so the port never glitches.

   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign cnt_d = (AW+1)'(cnt_q + push - pop);
   // Ready is worked out one edge ahead from the next count, so it matches the count exactly.
   assign in_ready = ready_q;
   assign out_valid = (cnt_q != '0);
   assign out_data = mem[rd_q];

   // Storage has no reset; only pointers, count and ready need a defined start.
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   // Pointers and fill count.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         ready_q <= 1'b1;
      end else begin
         if (push) begin
            wr_q <= AW'(wr_q + 1'b1);
         end
         if (pop) begin
            rd_q <= AW'(rd_q + 1'b1);
         end
         cnt_q <= cnt_d;
         ready_q <= (cnt_d != (AW+1)'(DEPTH));
      end
   end
endmodule : lcd_host_fifo

// >>> lcd_host_ctrl.sv
// Functional notes
// - Bytes move over eight bidirectional data lines.
// - Serial: top line data, next line clock.
// - Flag low command, flag high display data.
// - Strobe style writes use low write strobe.
// - Direction high reads, direction low writes.
// - Two straps pick bus style or reset.
`timescale 1ns/1ps
module lcd_host_ctrl
   import lcd_host_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rstn,
   // Write request stream: byte plus data/command flag.
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [DATA_W-1:0] wr_byte,
   input wire logic wr_is_display,
   // Read request and answer.
   input wire logic rd_req,
   input wire logic rd_is_display,
   output logic rd_done,
   output logic [DATA_W-1:0] rd_byte,
   output logic busy,
   // Bus style straps driven to the device.
   input wire logic [1:0] style_sel,
   output logic bus_type_pin_a,
   output logic bus_type_pin_b,
   // Device pins.
   output logic chip_select_low_n,
   output logic chip_select_high,
   output logic data_command_flag,
   output logic read_strobe_n,
   output logic write_strobe_n,
   input wire logic [DATA_W-1:0] host_data_bus_i,
   output logic [DATA_W-1:0] host_data_bus_o,
   output logic [DATA_W-1:0] host_data_bus_oe_n
);
   // ==========================================================
   // Helpers.
   // ==========================================================
   // Map a strap pair to the bus style it selects.
   function automatic bus_style_e style_of(input logic [1:0] s);
      case (s)
         STRAP_STROBE: style_of = BUS_STROBE;
         STRAP_ENABLE: style_of = BUS_ENABLE;
         STRAP_SERIAL: style_of = BUS_SERIAL;
         default: style_of = BUS_RESET;
      endcase
   endfunction : style_of

   // ==========================================================
   // Write FIFO: the data path is buffered so callers can burst.
   // ==========================================================
   logic [WORD_W-1:0] f_data;  // Head word.
   logic f_valid;  // Head word present.
   logic f_pop;  // Sequencer takes the head.
   lcd_host_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .in_valid(wr_valid),
      .in_ready(wr_ready),
      .in_data({wr_is_display, wr_byte}),
      .out_ready(f_pop),
      .out_valid(f_valid),
      .out_data(f_data)
   );

   // ==========================================================
   // Read data synchroniser: three flops, change taken once the
   // second and third agree.
   // ==========================================================
   logic [DATA_W-1:0] rs1_q, rs2_q, rs3_q;  // Sync stages.
   always_ff @(posedge clk_sys) begin
      rs1_q <= host_data_bus_i;
      rs2_q <= rs1_q;
      rs3_q <= rs2_q;
   end
   wire rd_stable = (rs2_q == rs3_q);

   // ==========================================================
   // Sequencer state.
   // ==========================================================
   seq_state_e st_q, st_d;  // Current and next state.
   bus_style_e style_q;  // Style latched at the last strap update.
   logic [3:0] cnt_q;  // Phase cycle counter.
   logic is_rd_q;  // Cycle in progress is a read.
   logic flag_q;  // Data/command flag of current cycle.
   logic [DATA_W-1:0] byte_q;  // Byte being written or shifted.
   logic [2:0] bit_q;  // Serial bit index.
   logic [DATA_W-1:0] rd_byte_q;  // Captured read byte.
   logic rd_done_q;  // One-cycle read completion pulse.

   wire phase_end = (cnt_q == CNT_ZERO);
   wire start_wr = (st_q == ST_IDLE) && f_valid && (style_q != BUS_RESET) && !rd_req;
   // Serial input is write-only, so reads are refused there.
   wire start_rd = (st_q == ST_IDLE) && rd_req && (style_q == BUS_STROBE
                   || style_q == BUS_ENABLE);
   wire ser = (style_q == BUS_SERIAL);
   assign f_pop = start_wr;

   // Next-state decode.
   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: begin
            if (start_rd || start_wr) begin
               st_d = ser ? ST_SLOW : ST_SETUP;
            end
         end
         ST_SETUP: st_d = phase_end ? ST_ACT : ST_SETUP;
         ST_ACT: st_d = (phase_end && (!is_rd_q || rd_stable)) ? ST_HOLD : ST_ACT;
         ST_HOLD: st_d = phase_end ? ST_IDLE : ST_HOLD;
         ST_SLOW: st_d = phase_end ? ST_SHIGH : ST_SLOW;
         ST_SHIGH: begin
            if (phase_end) begin
               st_d = (bit_q == BIT_LAST) ? ST_HOLD : ST_SLOW;
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end

   // State, counter and cycle context.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         st_q <= ST_IDLE;
         cnt_q <= CNT_ZERO;
         is_rd_q <= 1'b0;
         flag_q <= 1'b0;
         byte_q <= '0;
         bit_q <= BIT_FIRST;
      end else begin
         st_q <= st_d;
         cnt_q <= (st_d != st_q) ? PHASE_CYC : (phase_end ? CNT_ZERO : 4'(cnt_q - 1'b1));
         if (start_rd) begin
            is_rd_q <= 1'b1;
            flag_q <= rd_is_display;
         end else if (start_wr) begin
            is_rd_q <= 1'b0;
            flag_q <= f_data[FLAG_BIT];
            byte_q <= f_data[DATA_W-1:0];
            bit_q <= BIT_FIRST;
         end else if (st_q == ST_SHIGH && phase_end) begin
            // Shift left so the next bit sits on the top line, MSB first.
            byte_q <= {byte_q[DATA_W-2:0], 1'b0};
            bit_q <= 3'(bit_q + 1'b1);
         end
      end
   end

   // Style is only taken while idle and no cycle starts, so the style that
   // chose the state path is also the one that drives the pins of that cycle.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         style_q <= BUS_RESET;
      end else if (st_q == ST_IDLE && st_d == ST_IDLE) begin
         style_q <= style_of(style_sel);
      end
   end

   // ==========================================================
   // Pin decode.
   // ==========================================================
   wire in_cyc = (st_q != ST_IDLE);
   wire act = (st_q == ST_ACT);
   wire drive = in_cyc && !is_rd_q;
   // Strobe style: separate low strobes; enable style: E high, R/W level.
   wire rd_n_d = (style_q == BUS_ENABLE) ? act : !(act && is_rd_q);
   wire wr_n_d = (style_q == BUS_ENABLE) ? is_rd_q : !(act && !is_rd_q);
   wire [DATA_W-1:0] ser_bits = {byte_q[DATA_W-1], (st_q == ST_SHIGH),
                                 {(DATA_W-2){1'b0}}};
   wire [DATA_W-1:0] bus_d = ser ? ser_bits : byte_q;
   wire sel_d = in_cyc && (style_q != BUS_RESET);
   wire [1:0] strap_d = (style_q == BUS_STROBE) ? STRAP_STROBE :
                        (style_q == BUS_ENABLE) ? STRAP_ENABLE :
                        (style_q == BUS_SERIAL) ? STRAP_SERIAL : STRAP_RESET;

   // Registered pins; all outputs come straight from flops.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         chip_select_low_n <= 1'b1;
         chip_select_high <= 1'b0;
         data_command_flag <= 1'b0;
         read_strobe_n <= 1'b1;
         write_strobe_n <= 1'b1;
         host_data_bus_o <= '0;
         host_data_bus_oe_n <= '1;
         bus_type_pin_a <= 1'b0;
         bus_type_pin_b <= 1'b0;
      end else begin
         chip_select_low_n <= !sel_d;
         chip_select_high <= sel_d;
         data_command_flag <= flag_q;
         read_strobe_n <= rd_n_d;
         write_strobe_n <= wr_n_d;
         host_data_bus_o <= bus_d;
         host_data_bus_oe_n <= {DATA_W{!drive}};
         bus_type_pin_a <= strap_d[1];
         bus_type_pin_b <= strap_d[0];
      end
   end

   // Read capture at the end of the active phase, with a done pulse.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         rd_byte_q <= '0;
         rd_done_q <= 1'b0;
      end else begin
         rd_done_q <= 1'b0;
         if (act && is_rd_q && phase_end && rd_stable) begin
            rd_byte_q <= rs3_q;
            rd_done_q <= 1'b1;
         end
      end
   end
   assign rd_byte = rd_byte_q;
   assign rd_done = rd_done_q;

   // Busy flop mirrors the sequencer's next state.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         busy <= 1'b0;
      end else begin
         busy <= (st_d != ST_IDLE);
      end
   end
   // Power-control (supply mode) commands are ordinary command bytes
   // written with the flag low; the controller passes them unchanged.
endmodule : lcd_host_ctrl

// >>> lcd_host_ctrl_checker.sv
`timescale 1ns/1ps
module lcd_host_ctrl_checker
   import lcd_host_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rstn,
   // Device pins.
   input wire logic bus_type_pin_a,
   input wire logic bus_type_pin_b,
   input wire logic chip_select_low_n,
   input wire logic chip_select_high,
   input wire logic data_command_flag,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic [DATA_W-1:0] host_data_bus_o,
   input wire logic [DATA_W-1:0] host_data_bus_oe_n
);
   // ==========
   // Decode of what the device sees.
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   wire logic [1:0] strap = {bus_type_pin_a, bus_type_pin_b};
   wire logic stb = strap == STRAP_STROBE;
   wire logic ena = strap == STRAP_ENABLE;
   wire logic sel = !chip_select_low_n && chip_select_high;
   wire logic drv = host_data_bus_oe_n == '0;
   wire logic rel = &host_data_bus_oe_n;
   // A selection that lasts across two edges.
   sequence sel_held;
      sel ##1 sel;
   endsequence
   // Enable high through two edges of one selected cycle.
   sequence e_held;
      (ena && sel && read_strobe_n) [*2];
   endsequence
   strap_reset_a: assert property (strap == STRAP_RESET |-> !sel)
      else $error("selected while straps hold reset");
   wr_selected_a: assert property (stb && !write_strobe_n |-> sel)
      else $error("write strobe without both selects");
   rd_release_a: assert property (stb && !read_strobe_n |-> sel && rel)
      else $error("host drives bus during read strobe");
   one_strobe_a: assert property (stb |-> read_strobe_n || write_strobe_n)
      else $error("both strobes low");
   wr_data_a: assert property (stb && !write_strobe_n ##1 !write_strobe_n
      |-> $stable(host_data_bus_o) && drv)
      else $error("write data moved under strobe");
   dir_stable_a: assert property (e_held |-> $stable(write_strobe_n))
      else $error("direction changed while enable high");
   dir_owner_a: assert property (ena && sel && read_strobe_n
      |-> (write_strobe_n ? rel : drv))
      else $error("bus owner disagrees with direction");
   idle_float_a: assert property (!sel |-> rel)
      else $error("host drives bus while unselected");
   flag_stable_a: assert property (sel_held |-> $stable(data_command_flag))
      else $error("flag moved inside a cycle");
   ser_edge_a: assert property (strap == STRAP_SERIAL && sel && !host_data_bus_oe_n[SER_DATA_BIT]
      && $changed(host_data_bus_o[SER_DATA_BIT]) |-> !host_data_bus_o[SER_CLK_BIT])
      else $error("serial data changed with clock high");
endmodule : lcd_host_ctrl_checker

bind lcd_host_ctrl lcd_host_ctrl_checker chk (.*);

// >>> lcd_dev_model.sv
`timescale 1ns/1ps
module lcd_dev_model
   import lcd_host_pkg::*;
#(
   parameter logic [DATA_W-1:0] RD_DISP = 8'hA5,
   parameter logic [DATA_W-1:0] RD_CTRL = 8'h3C
) (
   // Straps and selects.
   input wire logic pin_a,
   input wire logic pin_b,
   input wire logic cs_low_n,
   input wire logic cs_high,
   // Transfer control.
   input wire logic flag,
   input wire logic rd_n,
   input wire logic wr_n,
   // Wire level and the device's own drive.
   input wire logic [DATA_W-1:0] bus,
   output logic [DATA_W-1:0] dev_out
);
   // ==========
   // Decode.
   wire logic [1:0] strap = {pin_a, pin_b};
   wire logic sel = !cs_low_n && cs_high;
   wire logic stb = strap == STRAP_STROBE;
   wire logic ena = strap == STRAP_ENABLE;
   wire logic [DATA_W-1:0] rd_val = flag ? RD_DISP : RD_CTRL;
   wire logic rd_on = sel && (stb ? !rd_n : ena && rd_n && wr_n);
   // Released lines show the inverse, so a late capture cannot pass by luck.
   assign dev_out = rd_on ? rd_val : ~rd_val;
   logic [DATA_W-1:0] last_q;
   logic [DATA_W-1:0] sh_q;
   logic last_flag;
   int bits;
   int wr_cnt = 0;
   // Records one received byte with its flag; power commands are plain commands.
   task automatic take(input logic [DATA_W-1:0] b);
      last_q = b;
      last_flag = flag;
      wr_cnt++;
   endtask : take
   always @(posedge wr_n) if (sel && stb) take(bus);
   always @(negedge rd_n) if (sel && ena && !wr_n) take(bus);
   always @(posedge sel) bits = 0;
   always @(posedge bus[SER_CLK_BIT]) begin
      if (sel && strap == STRAP_SERIAL) begin
         sh_q = {sh_q[DATA_W-2:0], bus[SER_DATA_BIT]};
         bits++;
         if (bits == DATA_W) begin
            take(sh_q);
            bits = 0;
         end
      end
   end
endmodule : lcd_dev_model

// >>> lcd_host_bus_interface_tb_top.sv
`timescale 1ns/1ps
module lcd_host_bus_interface_tb_top import lcd_host_pkg::*; ;
   // ==========
   // Signals.
   logic clk_sys = 1'b0, rstn = 1'b0, wr_valid = 1'b0, wr_is_display = 1'b0;
   logic rd_req = 1'b0, rd_is_display = 1'b0, wr_ready, rd_done, busy;
   logic bus_type_pin_a, bus_type_pin_b, chip_select_low_n, chip_select_high;
   logic data_command_flag, read_strobe_n, write_strobe_n;
   logic [1:0] style_sel = STRAP_RESET;
   logic [DATA_W-1:0] wr_byte = '0, rd_byte, host_data_bus_o, host_data_bus_oe_n, dev_out;
   wire logic [DATA_W-1:0] host_data_bus_i = (host_data_bus_oe_n & dev_out)
      | (~host_data_bus_oe_n & host_data_bus_o);
   int error_cnt = 0, checks = 0;
   lcd_host_ctrl dut (.*);
   lcd_dev_model dev (.pin_a(bus_type_pin_a), .pin_b(bus_type_pin_b),
      .cs_low_n(chip_select_low_n), .cs_high(chip_select_high),
      .flag(data_command_flag), .rd_n(read_strobe_n), .wr_n(write_strobe_n),
      .bus(host_data_bus_i), .dev_out(dev_out));
   initial forever #5 clk_sys = ~clk_sys;
   // ==========
   // Shared tasks.
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Straps change only between cycles, so let the host settle first.
   task automatic set_style(input logic [1:0] s);
      repeat (50) if (busy !== 1'b0) @(negedge clk_sys);
      chk({8'h00, busy}, 9'h000);
      @(posedge clk_sys);
      style_sel <= s;
      repeat (3) @(posedge clk_sys);
   endtask : set_style
   task automatic push(input logic [8:0] w);
      wr_byte <= w[7:0];
      wr_is_display <= w[8];
      wr_valid <= 1'b1;
      do @(posedge clk_sys); while (wr_ready !== 1'b1);
      wr_valid <= 1'b0;
   endtask : push
   task automatic wait_cnt(input int n);
      repeat (3000) if (dev.wr_cnt < n) @(posedge clk_sys);
   endtask : wait_cnt
   // ==========
   // Scenarios.
   task automatic t_write(input logic [1:0] s, input logic [8:0] w);
      int n = dev.wr_cnt;
      set_style(s);
      push(w);
      wait_cnt(n + 1);
      chk({dev.last_flag, dev.last_q}, w);
      $display("write test done");
   endtask : t_write
   task automatic t_read(input logic [1:0] s, input logic f);
      set_style(s);
      rd_is_display <= f;
      rd_req <= 1'b1;
      repeat (300) if (rd_done !== 1'b1) @(negedge clk_sys);
      chk({rd_done, rd_byte}, {1'b1, f ? dev.RD_DISP : dev.RD_CTRL});
      chk({8'h00, busy}, 9'h001);
      @(posedge clk_sys);
      rd_req <= 1'b0;
      $display("read test done");
   endtask : t_read
   // Reset straps hold writes back; serial style never starts a read.
   task automatic t_refuse;
      int n = dev.wr_cnt;
      logic seen = 1'b0;
      set_style(STRAP_RESET);
      push(9'h15A);
      repeat (100) @(posedge clk_sys);
      rd_req <= 1'b1;
      set_style(STRAP_SERIAL);
      repeat (100) begin
         @(posedge clk_sys);
         seen |= rd_done;
      end
      chk({seen, 8'(dev.wr_cnt - n)}, 9'h000);
      rd_req <= 1'b0;
      wait_cnt(n + 1);
      chk({dev.last_flag, dev.last_q}, 9'h15A);
      $display("refusal test done");
   endtask : t_refuse
   // Fill until refused while parked, then drain through the slow device.
   task automatic t_fifo;
      int k = 0;
      int n = dev.wr_cnt;
      set_style(STRAP_RESET);
      wr_is_display <= 1'b0;
      wr_byte <= '0;
      wr_valid <= 1'b1;
      repeat (40) begin
         @(posedge clk_sys);
         if (wr_ready === 1'b1) k++;
         wr_byte <= 8'(k);
      end
      wr_valid <= 1'b0;
      chk({wr_ready, 8'(k)}, {1'b0, 8'(FIFO_DEPTH)});
      set_style(STRAP_STROBE);
      wait_cnt(n + FIFO_DEPTH);
      chk({wr_ready, dev.last_q}, {1'b1, 8'(FIFO_DEPTH - 1)});
      $display("fifo test done");
   endtask : t_fifo
   task automatic finish_test;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test
   // ==========
   // Main sequence and watchdog.
   initial begin
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      t_write(STRAP_STROBE, 9'h0AF);
      t_write(STRAP_STROBE, 9'h1C3);
      t_write(STRAP_ENABLE, 9'h081);
      t_write(STRAP_ENABLE, 9'h15A);
      t_write(STRAP_SERIAL, 9'h196);
      t_read(STRAP_STROBE, 1'b1);
      t_read(STRAP_STROBE, 1'b0);
      t_read(STRAP_ENABLE, 1'b1);
      t_read(STRAP_ENABLE, 1'b0);
      t_refuse;
      t_fifo;
      finish_test;
   end
   initial begin
      #400_000;
      error_cnt++;
      $display("[ERR] %0t watchdog expired", $time);
      finish_test;
   end
endmodule : lcd_host_bus_interface_tb_top
